/* rtl/pwm_and_system_config_regs.sv */
`timescale 1ns/1ps
module pwm_and_system_config_regs #(
	parameter int STEP_CYC_0 = pwm_cfg_pkg::STEP_CYC_0,
	parameter int STEP_CYC_1 = pwm_cfg_pkg::STEP_CYC_1,
	parameter int STEP_CYC_2 = pwm_cfg_pkg::STEP_CYC_2,
	parameter int STEP_CYC_3 = pwm_cfg_pkg::STEP_CYC_3
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic reset_n,
	// Register access from the serial interface
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic chip_select_low_active,
	// Device state
	input wire logic [2:0] sbc_mode,
	input wire logic soft_reset,
	input wire logic restart_enter,
	input wire logic cfg_lock0,
	input wire logic cfg_lock1_req,
	input wire logic mpp_hw_update,
	input wire logic [2:0] mpp_active_cfg,
	// Outputs to the analog and switch logic
	output logic [2:0] mpp_config,
	output logic wake_source_default,
	output logic low_side_switch,
	output logic high_side_switch,
	output logic thermal_trip_select,
	output logic [1:0] main_reg_current_limit,
	output logic cfg_lock1_active
);
	// Step lengths must fit the prescaler, refused at elaboration
	if (STEP_CYC_0 < 1 || STEP_CYC_0 >= (1 << pwm_cfg_pkg::STEP_CNT_W) ||
		STEP_CYC_1 < 1 || STEP_CYC_1 >= (1 << pwm_cfg_pkg::STEP_CNT_W) ||
		STEP_CYC_2 < 1 || STEP_CYC_2 >= (1 << pwm_cfg_pkg::STEP_CNT_W) ||
		STEP_CYC_3 < 1 || STEP_CYC_3 >= (1 << pwm_cfg_pkg::STEP_CNT_W)) begin : g_bad_step
		$error("step cycle parameter out of range");
	end

	function automatic logic [15:0] step_len(input logic [1:0] sel);
		logic [15:0] len;
		len = 16'(STEP_CYC_0);
		unique case (sel)
			2'h0: len = 16'(STEP_CYC_0);
			2'h1: len = 16'(STEP_CYC_1);
			2'h2: len = 16'(STEP_CYC_2);
			2'h3: len = 16'(STEP_CYC_3);
		endcase
		return len;
	endfunction : step_len

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [2:0] mpp_cfg_q, mpp_cfg_d;
	logic [7:0] duty_q, duty_d;
	logic [1:0] rate_q, rate_d;
	logic trip_q, trip_d;
	logic [1:0] ilim_q, ilim_d;
	logic [7:0] store_lo_q, store_lo_d;
	logic [7:0] store_hi_q, store_hi_d;
	logic lock1_q, lock1_d;
	logic cs_q, cs_d;
	logic [7:0] rdata_q, rdata_d;
	logic wr_normal;

	assign wr_normal = reg_wr && (sbc_mode == pwm_cfg_pkg::MODE_NORMAL);

	always_comb begin
		mpp_cfg_d = mpp_cfg_q;
		duty_d = duty_q;
		rate_d = rate_q;
		trip_d = trip_q;
		ilim_d = ilim_q;
		store_lo_d = store_lo_q;
		store_hi_d = store_hi_q;
		lock1_d = lock1_q;
		rdata_d = rdata_q;
		cs_d = chip_select_low_active;
		// Lock engages on the chip-select rise and only power-up clears it
		if (!cs_q && chip_select_low_active && cfg_lock1_req) begin
			lock1_d = 1'b1;
		end
		if (reg_wr) begin
			unique case (reg_addr)
				pwm_cfg_pkg::OFS_MPP_CONFIG: begin
					if (!cfg_lock0) begin
						mpp_cfg_d = reg_wdata[pwm_cfg_pkg::MPP_CFG_W-1:0];
					end
				end
				pwm_cfg_pkg::OFS_PWM_DUTY_CYCLE: duty_d = reg_wdata;
				pwm_cfg_pkg::OFS_PWM_FREQUENCY_SELECT: begin
					rate_d = reg_wdata[pwm_cfg_pkg::RATE_SEL_W-1:0];
				end
				pwm_cfg_pkg::OFS_PROTECTION_LIMIT_CONFIG: begin
					if (!lock1_q) begin
						trip_d = reg_wdata[pwm_cfg_pkg::THERMAL_TRIP_POS];
						ilim_d = reg_wdata[pwm_cfg_pkg::CURRENT_LIMIT_W-1:0];
					end
				end
				pwm_cfg_pkg::OFS_SYSTEM_STORE_LOW: begin
					if (wr_normal) begin
						store_lo_d = reg_wdata;
					end
				end
				pwm_cfg_pkg::OFS_SYSTEM_STORE_HIGH: begin
					if (wr_normal) begin
						store_hi_d = reg_wdata;
					end
				end
				default: ;
			endcase
		end
		// Hardware may move the pin config, e.g. on a mode change
		if (mpp_hw_update) begin
			mpp_cfg_d = mpp_active_cfg;
		end
		if (restart_enter) begin
			mpp_cfg_d = mpp_active_cfg;
		end
		// Store bytes are absent here: they survive soft reset and restart
		if (soft_reset) begin
			duty_d = pwm_cfg_pkg::DUTY_POR;
			rate_d = pwm_cfg_pkg::RATE_SEL_POR;
			mpp_cfg_d = cfg_lock0 ? mpp_active_cfg : pwm_cfg_pkg::MPP_CFG_POR;
			if (!lock1_q) begin
				trip_d = pwm_cfg_pkg::THERMAL_TRIP_POR;
				ilim_d = pwm_cfg_pkg::CURRENT_LIMIT_POR;
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				pwm_cfg_pkg::OFS_MPP_CONFIG: rdata_d = {5'h00, mpp_cfg_q};
				pwm_cfg_pkg::OFS_PWM_DUTY_CYCLE: rdata_d = duty_q;
				pwm_cfg_pkg::OFS_PWM_FREQUENCY_SELECT: rdata_d = {6'h00, rate_q};
				pwm_cfg_pkg::OFS_PROTECTION_LIMIT_CONFIG: rdata_d = {5'h00, trip_q, ilim_q};
				pwm_cfg_pkg::OFS_SYSTEM_STORE_LOW: rdata_d = store_lo_q;
				pwm_cfg_pkg::OFS_SYSTEM_STORE_HIGH: rdata_d = store_hi_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mpp_cfg_q <= pwm_cfg_pkg::MPP_CFG_POR;
			duty_q <= pwm_cfg_pkg::DUTY_POR;
			rate_q <= pwm_cfg_pkg::RATE_SEL_POR;
			trip_q <= pwm_cfg_pkg::THERMAL_TRIP_POR;
			ilim_q <= pwm_cfg_pkg::CURRENT_LIMIT_POR;
			store_lo_q <= pwm_cfg_pkg::STORE_POR;
			store_hi_q <= pwm_cfg_pkg::STORE_POR;
			lock1_q <= 1'b0;
			cs_q <= 1'b1;
			rdata_q <= 8'h00;
		end else begin
			mpp_cfg_q <= mpp_cfg_d;
			duty_q <= duty_d;
			rate_q <= rate_d;
			trip_q <= trip_d;
			ilim_q <= ilim_d;
			store_lo_q <= store_lo_d;
			store_hi_q <= store_hi_d;
			lock1_q <= lock1_d;
			cs_q <= cs_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// PWM generator
	// ----------------------------------------------------------------
	// Active copies change only at the period boundary so a write never
	// tears a running period; the cost is up to one period of latency.
	logic [15:0] pre_q, pre_d;
	logic [7:0] step_q, step_d;
	logic [7:0] act_duty_q, act_duty_d;
	logic [1:0] act_rate_q, act_rate_d;
	logic ls_q, ls_d, hs_q, hs_d;
	logic pwm_on;

	always_comb begin
		pre_d = pre_q + 16'h0001;
		step_d = step_q;
		act_duty_d = act_duty_q;
		act_rate_d = act_rate_q;
		if (pre_q >= step_len(act_rate_q) - 16'h0001) begin
			pre_d = 16'h0000;
			if (step_q == pwm_cfg_pkg::LAST_STEP) begin
				step_d = 8'h00;
				act_duty_d = duty_q;
				act_rate_d = rate_q;
			end else begin
				step_d = step_q + 8'h01;
			end
		end
		// All ones is forced fully on by a special-case compare with DUTY_FULL_ON
		pwm_on = (act_duty_q == pwm_cfg_pkg::DUTY_FULL_ON) || (step_q < act_duty_q);
		ls_d = pwm_on && (mpp_cfg_q == pwm_cfg_pkg::MPP_PWM_LOW_SIDE);
		hs_d = pwm_on && (mpp_cfg_q == pwm_cfg_pkg::MPP_PWM_HIGH_SIDE);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pre_q <= 16'h0000;
			step_q <= 8'h00;
			act_duty_q <= pwm_cfg_pkg::DUTY_POR;
			act_rate_q <= pwm_cfg_pkg::RATE_SEL_POR;
			ls_q <= 1'b0;
			hs_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			step_q <= step_d;
			act_duty_q <= act_duty_d;
			act_rate_q <= act_rate_d;
			ls_q <= ls_d;
			hs_q <= hs_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign mpp_config = mpp_cfg_q;
	assign wake_source_default = (mpp_cfg_q == pwm_cfg_pkg::MPP_WAKE_INPUT) &&
		(sbc_mode == pwm_cfg_pkg::MODE_FAIL_SAFE);
	assign low_side_switch = ls_q;
	assign high_side_switch = hs_q;
	assign thermal_trip_select = trip_q;
	assign main_reg_current_limit = ilim_q;
	assign cfg_lock1_active = lock1_q;
endmodule : pwm_and_system_config_regs

/* rtl/pwm_cfg_pkg.sv */
package pwm_cfg_pkg;
	// ----------------------------------------------------------------
	// Register offsets (7-bit register address)
	// ----------------------------------------------------------------
	localparam logic [6:0] OFS_MPP_CONFIG = 7'h17;
	localparam logic [6:0] OFS_PWM_DUTY_CYCLE = 7'h18;
	localparam logic [6:0] OFS_PWM_FREQUENCY_SELECT = 7'h1C;
	localparam logic [6:0] OFS_PROTECTION_LIMIT_CONFIG = 7'h1D;
	localparam logic [6:0] OFS_SYSTEM_STORE_LOW = 7'h1E;
	localparam logic [6:0] OFS_SYSTEM_STORE_HIGH = 7'h1F;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int MPP_CFG_W = 3;
	localparam int RATE_SEL_W = 2;
	localparam int THERMAL_TRIP_POS = 2;
	localparam int CURRENT_LIMIT_W = 2;
	localparam logic [2:0] MPP_CFG_POR = 3'h0;
	localparam logic [7:0] DUTY_POR = 8'h00;
	localparam logic [1:0] RATE_SEL_POR = 2'h0;
	localparam logic THERMAL_TRIP_POR = 1'b0;
	localparam logic [1:0] CURRENT_LIMIT_POR = 2'h1;
	localparam logic [7:0] STORE_POR = 8'h00;
	localparam logic [7:0] DUTY_FULL_ON = 8'hFF;

	// ----------------------------------------------------------------
	// Multi-purpose pin configurations and operating modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MPP_WAKE_INPUT = 3'h5;
	localparam logic [2:0] MPP_PWM_LOW_SIDE = 3'h6;
	localparam logic [2:0] MPP_PWM_HIGH_SIDE = 3'h7;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_STOP = 3'h1;
	localparam logic [2:0] MODE_SLEEP = 3'h2;
	localparam logic [2:0] MODE_RESTART = 3'h3;
	localparam logic [2:0] MODE_FAIL_SAFE = 3'h4;

	// ----------------------------------------------------------------
	// PWM timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int PERIOD_STEPS = 255;
	localparam logic [7:0] LAST_STEP = 8'hFE;
	localparam int RATE_HZ_0 = 100;
	localparam int RATE_HZ_1 = 200;
	localparam int RATE_HZ_2 = 325;
	localparam int RATE_HZ_3 = 400;
	// Longest step that still fits the period: round down
	localparam int STEP_CYC_0 = CLK_HZ / (RATE_HZ_0 * PERIOD_STEPS);
	localparam int STEP_CYC_1 = CLK_HZ / (RATE_HZ_1 * PERIOD_STEPS);
	localparam int STEP_CYC_2 = CLK_HZ / (RATE_HZ_2 * PERIOD_STEPS);
	localparam int STEP_CYC_3 = CLK_HZ / (RATE_HZ_3 * PERIOD_STEPS);
	localparam int STEP_CNT_W = 16;
endpackage : pwm_cfg_pkg

/* verification/pwm_and_system_config_regs_properties.sv */
`timescale 1ns/1ps
module pwm_cfg_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port and device state
	input wire logic [6:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic chip_select_low_active,
	input wire logic cfg_lock1_req,
	input wire logic soft_reset,
	input wire logic [2:0] sbc_mode,
	// Outputs
	input wire logic [2:0] mpp_config,
	input wire logic wake_source_default,
	input wire logic high_side_switch,
	input wire logic low_side_switch,
	input wire logic thermal_trip_select,
	input wire logic [1:0] main_reg_current_limit,
	input wire logic cfg_lock1_active
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Lock arms on the release of chip select while the request is held
	sequence s_arm;
		$rose(chip_select_low_active) && cfg_lock1_req;
	endsequence
	chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {7'h17, 7'h18,
		[7'h1C:7'h1F]}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_rate_reserved: assert property (reg_rd && reg_addr == 7'h1C |=>
		reg_rdata[7:2] == 6'h00) else $error("rate reserved bits set");
	chk_wake_default: assert property (wake_source_default == (mpp_config == 3'h5
		&& sbc_mode == 3'h4)) else $error("wake source wrong");
	chk_high_gate: assert property (high_side_switch |-> $past(mpp_config) == 3'h7)
		else $error("high side on in wrong config");
	chk_low_gate: assert property (low_side_switch |-> $past(mpp_config) == 3'h6)
		else $error("low side on in wrong config");
	chk_lock_arms: assert property (s_arm |=> cfg_lock1_active)
		else $error("lock did not arm");
	chk_lock_sticks: assert property (cfg_lock1_active |=> cfg_lock1_active)
		else $error("lock dropped");
	chk_limits_frozen: assert property (cfg_lock1_active |=> $stable(thermal_trip_select)
		&& $stable(main_reg_current_limit)) else $error("locked limits changed");
	chk_soft_limits: assert property (soft_reset && !cfg_lock1_active |=>
		!thermal_trip_select && main_reg_current_limit == 2'h1) else $error("limits not reset");
endmodule : pwm_cfg_props

bind pwm_and_system_config_regs pwm_cfg_props u_props (.clk, .reset_n, .reg_addr, .reg_rd,
	.reg_rdata, .chip_select_low_active, .cfg_lock1_req, .soft_reset, .sbc_mode, .mpp_config,
	.wake_source_default, .high_side_switch, .low_side_switch, .thermal_trip_select,
	.main_reg_current_limit, .cfg_lock1_active);

/* verification/pwm_and_system_config_regs_tb.sv */
`timescale 1ns/1ps
module pwm_and_system_config_regs_tb;
	// Short steps keep each period near a thousand cycles at most
	localparam int STP[4] = '{2, 2, 3, 4};
	logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, soft_reset = 1'b0;
	logic chip_select_low_active = 1'b1, restart_enter = 1'b0, cfg_lock0 = 1'b0;
	logic cfg_lock1_req = 1'b0, mpp_hw_update = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [2:0] sbc_mode = 3'h0, mpp_active_cfg = 3'h0, mpp_config;
	logic wake_source_default, low_side_switch, high_side_switch;
	logic thermal_trip_select, cfg_lock1_active;
	logic [1:0] main_reg_current_limit;
	wire sw = high_side_switch | low_side_switch;
	int bad_count = 0, n_checks = 0, h;
	pwm_and_system_config_regs #(.STEP_CYC_0(STP[0]), .STEP_CYC_1(STP[1]),
		.STEP_CYC_2(STP[2]), .STEP_CYC_3(STP[3])) uut (.clk, .reset_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_select_low_active, .sbc_mode,
		.soft_reset, .restart_enter, .cfg_lock0, .cfg_lock1_req, .mpp_hw_update,
		.mpp_active_cfg, .mpp_config, .wake_source_default, .low_side_switch,
		.high_side_switch, .thermal_trip_select, .main_reg_current_limit, .cfg_lock1_active);
	initial forever #2.5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(16'(reg_rdata), 16'(e));
	endtask : rd
	task automatic sr;
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
	endtask : sr
	// Sampled on falling edges so the count never races the switch update
	task automatic meas(input int len, input bit al, output int hi);
		int i;
		hi = 0;
		@(negedge clk);
		for (i = 0; al && i < 3000 && sw === 1'b1; i++) @(negedge clk);
		for (i = 0; al && i < 3000 && sw !== 1'b1; i++) @(negedge clk);
		for (i = 0; i < len; i++) begin
			hi += (sw === 1'b1);
			@(negedge clk);
		end
	endtask : meas
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		test_done;
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(7'h1D, 8'h01);
		rd(7'h1E, 8'h00);
		wr(7'h1C, 8'hFF);
		rd(7'h1C, 8'h03);
		wr(7'h1D, 8'hFE);
		rd(7'h1D, 8'h06);
		chk(16'({thermal_trip_select, main_reg_current_limit}), 16'h0006);
		wr(7'h20, 8'h5A);
		rd(7'h20, 8'h00);
		$display("test registers done");
		@(posedge clk) sbc_mode <= 3'h1;
		wr(7'h1E, 8'h5A);
		rd(7'h1E, 8'h00);
		@(posedge clk) sbc_mode <= 3'h0;
		wr(7'h1E, 8'h5A);
		wr(7'h1F, 8'hA5);
		sr;
		@(posedge clk) sbc_mode <= 3'h4;
		rd(7'h1E, 8'h5A);
		rd(7'h1F, 8'hA5);
		rd(7'h1D, 8'h01);
		wr(7'h17, 8'h05);
		@(negedge clk);
		chk(16'(wake_source_default), 16'h0001);
		@(posedge clk) sbc_mode <= 3'h0;
		$display("test store done");
		@(posedge clk);
		mpp_active_cfg <= 3'h3;
		restart_enter <= 1'b1;
		@(posedge clk);
		restart_enter <= 1'b0;
		rd(7'h17, 8'h03);
		chk(16'(mpp_config), 16'h0003);
		@(posedge clk);
		mpp_active_cfg <= 3'h4;
		mpp_hw_update <= 1'b1;
		cfg_lock0 <= 1'b1;
		@(posedge clk);
		mpp_hw_update <= 1'b0;
		wr(7'h17, 8'h06);
		rd(7'h17, 8'h04);
		sr;
		rd(7'h17, 8'h04);
		@(posedge clk) cfg_lock0 <= 1'b0;
		sr;
		rd(7'h17, 8'h00);
		$display("test pin config done");
		wr(7'h18, 8'h40);
		wr(7'h17, 8'h07);
		for (int r = 0; r < 4; r++) begin
			wr(7'h1C, 8'(r));
			meas(255 * STP[r], 1'b1, h);
			chk(16'(h), 16'(64 * STP[r]));
		end
		wr(7'h18, 8'hFF);
		wr(7'h17, 8'h06);
		repeat (1100) @(posedge clk);
		meas(1020, 1'b0, h);
		chk(16'(h), 16'h03FC);
		chk(16'({low_side_switch, high_side_switch}), 16'h0002);
		wr(7'h18, 8'h00);
		repeat (1100) @(posedge clk);
		meas(1020, 1'b0, h);
		chk(16'(h), 16'h0000);
		$display("test pwm done");
		wr(7'h1D, 8'h06);
		@(posedge clk);
		cfg_lock1_req <= 1'b1;
		chip_select_low_active <= 1'b0;
		@(posedge clk);
		chip_select_low_active <= 1'b1;
		repeat (2) @(posedge clk);
		wr(7'h1D, 8'h01);
		rd(7'h1D, 8'h06);
		chk(16'(cfg_lock1_active), 16'h0001);
		sr;
		rd(7'h1D, 8'h06);
		$display("test lock done");
		test_done;
	end
endmodule : pwm_and_system_config_regs_tb
